// ---- inc/adcrb_regs.svh ----
`ifndef ADCRB_REGS_SVH
`define ADCRB_REGS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADCRB_OFS_IO_PORT     6'h01
`define ADCRB_OFS_REVISION    6'h02
`define ADCRB_OFS_TEST        6'h03
`define ADCRB_OFS_READY       6'h04
`define ADCRB_OFS_CHECKSUM    6'h05
`define ADCRB_OFS_ADC_ZERO    6'h06
`define ADCRB_OFS_ADC_GAIN    6'h07
`define ADCRB_OFS_CH_RESULT   6'h08
`define ADCRB_OFS_CH_ZERO     6'h10
// ----------------------------------------
// Port register fields
// ----------------------------------------
`define ADCRB_BIT_PIN_A       7
`define ADCRB_BIT_PIN_B       6
`define ADCRB_BIT_DIR_A       5
`define ADCRB_BIT_DIR_B       4
`define ADCRB_BIT_RDY_FN      3
`define ADCRB_BIT_LOW_PWR     2
`define ADCRB_BIT_SYNC_EN     0
// ----------------------------------------
// Reset values
// ----------------------------------------
`define ADCRB_RST_DIR         1'b1
`define ADCRB_RST_COEFF       24'h800000
`define ADCRB_RST_RESULT      24'h008000
`define ADCRB_RST_FLAGS       8'h00
`define ADCRB_ALL_FLAGS       8'hff
// Generic part code: arbitrary value
`define ADCRB_GENERIC_CODE    4'h6
`define ADCRB_CH_ZERO_MASK    24'hbfffff
`endif

// ---- inc/adcrb_pkg.sv ----
package adcrb_pkg;
    typedef enum logic [1:0] {
        CAL_ADC_ZERO,
        CAL_ADC_GAIN,
        CAL_CH_ZERO,
        CAL_OTHER
    } adcrb_cal_e;
    typedef logic [2:0]  adcrb_ch_t;
    typedef logic [23:0] adcrb_word_t;
endpackage

// ---- logic/adcrb_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "adcrb_regs.svh"
// Functional notes
// RULE1 - Output pins follow their port bit; input pins read back live.
// RULE2 - Direction bit 1 means input, 0 output; both reset to 1.
// RULE3 - Ready low on any unread channel, or all enabled with function bit.
// RULE4 - Low power bit selects reduced power; clock then at most 4 MHz.
// RULE5 - Host always writes 0 to port register bit 1.
// RULE6 - Sync bit resets 0; when set pin b synchronises modulator and filter.
// RULE7 - Revision reads revision code high nibble, generic code low nibble.
// RULE8 - Host leaves the factory test register at its default.
// RULE9 - Finished conversion updates channel data and sets its ready flag.
// RULE10 - Reading channel data clears that channel's ready flag.
// RULE11 - Flag also clears while an unread result is being overwritten.
// RULE12 - Any mode register write clears all eight ready flags.
// RULE13 - Calibration holds all flags 0, then sets all to 1 at the end.
// RULE14 - Ready flag bit n belongs to channel n.
// RULE15 - Coefficient writes take effect only in idle mode.
// RULE16 - Converter zero coefficient loads after its self calibration.
// RULE17 - Host runs gain self calibration only on 2.5 V ranges.
// RULE18 - Channel data 16 bits reset 0x8000, 24 bits when width bit set.
// RULE19 - A result arriving during any data read is dropped.
// RULE20 - Status accompanies data in continuous read, optionally in dump.
// RULE21 - Channel zero coefficient is sign plus 22 bit magnitude, auto loaded.
// RULE22 - Converter and channel coefficients scale every channel result.
// RULE23 - Command read/write bit: 0 write, 1 read.
// RULE24 - Six bit address selects register; low three bits give channel.
// RULE25 - Reserved bits read 0 and ignore writes.
module adcrb_regs #(
    parameter logic [3:0]  REVISION_CODE = 4'h1, // Arbitrary value
    parameter logic [23:0] TEST_DEFAULT  = 24'h000000,
    parameter logic [15:0] CSUM_DEFAULT  = 16'h0000
) (
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        cmd_valid_i,
    input  wire logic        cmd_rw_i,
    input  wire logic [5:0]  cmd_addr_i,
    input  wire logic [23:0] cmd_wdata_i,
    output logic      [23:0] rd_data_o,
    output logic      [7:0]  rd_status_o,
    output logic             rd_status_vld_o,
    input  wire logic        read_busy_i,
    input  wire logic        cont_read_i,
    input  wire logic        dump_status_i,
    input  wire logic        mode_write_i,
    input  wire logic        mode_wide_i,
    input  wire logic        mode_idle_i,
    input  wire logic        mode_cal_i,
    input  wire logic [7:0]  ch_enable_i,
    input  wire logic        conv_done_i,
    input  wire logic [2:0]  conv_ch_i,
    input  wire logic [23:0] conv_raw_i,
    input  wire logic        cal_done_i,
    input  wire logic [1:0]  cal_kind_i,
    input  wire logic [2:0]  cal_ch_i,
    input  wire logic [23:0] cal_coeff_i,
    input  wire logic        port_pin_a_i,
    output logic             port_pin_a_o,
    output logic             port_pin_a_oe_n_o,
    input  wire logic        port_pin_b_i,
    output logic             port_pin_b_o,
    output logic             port_pin_b_oe_n_o,
    output logic             filter_sync_o,
    output logic             ready_n_o,
    output logic             low_power_select_o
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [7:0]  flags_reg, flags_next;
    logic [23:0] result_reg [8], result_next [8];
    logic [23:0] ch_zero_reg [8], ch_zero_next [8];
    logic [23:0] adc_zero_reg, adc_zero_next;
    logic [23:0] adc_gain_reg, adc_gain_next;
    logic [23:0] test_reg, test_next;
    logic [15:0] csum_reg, csum_next;
    logic        pin_a_reg, pin_a_next, pin_b_reg, pin_b_next;
    logic        dir_a_reg, dir_a_next, dir_b_reg, dir_b_next;
    logic        rdy_fn_reg, rdy_fn_next, low_pwr_reg, low_pwr_next;
    logic        sync_en_reg, sync_en_next;
    logic        upd_vld_reg, upd_vld_next;
    logic [2:0]  upd_ch_reg, upd_ch_next;
    logic [23:0] upd_data_reg, upd_data_next;
    logic [23:0] rd_data_next;
    logic [7:0]  rd_status_next;
    logic        rd_status_vld_next;

    function automatic logic in_bank(input logic [5:0] a,
                                     input logic [5:0] base);
        in_bank = (a[5:3] == base[5:3]);
    endfunction

    logic        wr, rd, rd_res;
    logic [7:0]  port_val;
    logic [23:0] offs, scaled, czv, czoff;
    logic [47:0] prod;
    assign wr     = cmd_valid_i && !cmd_rw_i;                    // [RULE23]
    assign rd     = cmd_valid_i && cmd_rw_i;                     // [RULE23]
    assign rd_res = rd && in_bank(cmd_addr_i, `ADCRB_OFS_CH_RESULT);

    // ----------------------------------------
    // Result scaling
    // ----------------------------------------
    // Offset binary throughout; gain 0x800000 is unity
    assign offs  = conv_raw_i - adc_zero_reg + `ADCRB_RST_COEFF;   // [RULE22]
    assign prod  = {24'h000000, offs} * {24'h000000, adc_gain_reg};
    assign czv   = ch_zero_reg[conv_ch_i];
    assign czoff = czv[23] ? ~{2'b00, czv[21:0]} + 24'h000001
                           : {2'b00, czv[21:0]};                 // [RULE21]
    assign scaled = prod[46:23] - czoff;                         // [RULE22]

    // ----------------------------------------
    // Port pins and ready output
    // ----------------------------------------
    assign port_pin_a_o      = pin_a_reg;                        // [RULE1]
    assign port_pin_a_oe_n_o = dir_a_reg;                        // [RULE2]
    assign port_pin_b_o      = pin_b_reg;
    // Sync function owns pin b, so never drive it then
    assign port_pin_b_oe_n_o = dir_b_reg || sync_en_reg;         // [RULE6]
    assign filter_sync_o     = sync_en_reg && !port_pin_b_i;     // [RULE6]
    assign low_power_select_o = low_pwr_reg;                     // [RULE4]
    assign ready_n_o = rdy_fn_reg
                     ? !((flags_reg & ch_enable_i) == ch_enable_i)
                     : !(|flags_reg);                            // [RULE3]
    always_comb begin
        port_val = 8'h00;                                        // [RULE25]
        port_val[`ADCRB_BIT_PIN_A] = dir_a_reg ? port_pin_a_i
                                               : pin_a_reg;      // [RULE1]
        port_val[`ADCRB_BIT_PIN_B] = dir_b_reg ? port_pin_b_i
                                               : pin_b_reg;      // [RULE1]
        port_val[`ADCRB_BIT_DIR_A]   = dir_a_reg;
        port_val[`ADCRB_BIT_DIR_B]   = dir_b_reg;
        port_val[`ADCRB_BIT_RDY_FN]  = rdy_fn_reg;
        port_val[`ADCRB_BIT_LOW_PWR] = low_pwr_reg;
        port_val[`ADCRB_BIT_SYNC_EN] = sync_en_reg;
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        flags_next    = flags_reg;
        result_next   = result_reg;
        ch_zero_next  = ch_zero_reg;
        adc_zero_next = adc_zero_reg;
        adc_gain_next = adc_gain_reg;
        test_next     = test_reg;
        csum_next     = csum_reg;
        pin_a_next    = pin_a_reg;
        pin_b_next    = pin_b_reg;
        dir_a_next    = dir_a_reg;
        dir_b_next    = dir_b_reg;
        rdy_fn_next   = rdy_fn_reg;
        low_pwr_next  = low_pwr_reg;
        sync_en_next  = sync_en_reg;
        upd_vld_next  = conv_done_i;
        upd_ch_next   = conv_ch_i;
        upd_data_next = mode_wide_i ? scaled
                                    : {8'h00, scaled[23:8]};     // [RULE18]
        rd_data_next  = rd_data_o;
        rd_status_next     = rd_status_o;
        rd_status_vld_next = 1'b0;

        // Clears first, so that any set below wins
        if (mode_write_i)
            flags_next = `ADCRB_RST_FLAGS;                       // [RULE12]
        if (mode_cal_i)
            flags_next = `ADCRB_RST_FLAGS;                       // [RULE13]
        if (rd_res)
            flags_next[cmd_addr_i[2:0]] = 1'b0;                  // [RULE10]
        if (conv_done_i)
            flags_next[conv_ch_i] = 1'b0;                        // [RULE11]
        // A read in flight keeps its data; that result is lost
        if (upd_vld_reg && !read_busy_i) begin                   // [RULE19]
            result_next[upd_ch_reg] = upd_data_reg;              // [RULE9]
            flags_next[upd_ch_reg]  = 1'b1;                      // [RULE14]
        end
        if (cal_done_i) begin
            flags_next = `ADCRB_ALL_FLAGS;                       // [RULE13]
            case (adcrb_pkg::adcrb_cal_e'(cal_kind_i))
                adcrb_pkg::CAL_ADC_ZERO:
                    adc_zero_next = cal_coeff_i;                 // [RULE16]
                adcrb_pkg::CAL_ADC_GAIN:
                    adc_gain_next = cal_coeff_i;
                adcrb_pkg::CAL_CH_ZERO:
                    ch_zero_next[cal_ch_i] =
                        cal_coeff_i & `ADCRB_CH_ZERO_MASK;       // [RULE21]
                default: ;
            endcase
        end

        if (wr) begin
            case (cmd_addr_i)                                    // [RULE24]
                `ADCRB_OFS_IO_PORT: begin
                    pin_a_next   = cmd_wdata_i[`ADCRB_BIT_PIN_A];
                    pin_b_next   = cmd_wdata_i[`ADCRB_BIT_PIN_B];
                    dir_a_next   = cmd_wdata_i[`ADCRB_BIT_DIR_A]; // [RULE2]
                    dir_b_next   = cmd_wdata_i[`ADCRB_BIT_DIR_B]; // [RULE2]
                    rdy_fn_next  = cmd_wdata_i[`ADCRB_BIT_RDY_FN];
                    low_pwr_next = cmd_wdata_i[`ADCRB_BIT_LOW_PWR];
                    sync_en_next = cmd_wdata_i[`ADCRB_BIT_SYNC_EN];
                end
                `ADCRB_OFS_TEST:     test_next = cmd_wdata_i;
                `ADCRB_OFS_CHECKSUM: csum_next = cmd_wdata_i[15:0];
                `ADCRB_OFS_ADC_ZERO:
                    if (mode_idle_i)
                        adc_zero_next = cmd_wdata_i;             // [RULE15]
                `ADCRB_OFS_ADC_GAIN:
                    if (mode_idle_i)
                        adc_gain_next = cmd_wdata_i;             // [RULE15]
                default:
                    if (in_bank(cmd_addr_i, `ADCRB_OFS_CH_ZERO) &&
                        mode_idle_i)
                        ch_zero_next[cmd_addr_i[2:0]] =
                            cmd_wdata_i & `ADCRB_CH_ZERO_MASK;   // [RULE15]
            endcase
        end

        if (rd) begin
            case (cmd_addr_i)                                    // [RULE24]
                `ADCRB_OFS_IO_PORT:  rd_data_next = {16'h0000, port_val};
                `ADCRB_OFS_REVISION:
                    rd_data_next = {16'h0000, REVISION_CODE,
                                    `ADCRB_GENERIC_CODE};        // [RULE7]
                `ADCRB_OFS_TEST:     rd_data_next = test_reg;
                `ADCRB_OFS_READY:
                    rd_data_next = {16'h0000, flags_reg};        // [RULE14]
                `ADCRB_OFS_CHECKSUM: rd_data_next = {8'h00, csum_reg};
                `ADCRB_OFS_ADC_ZERO: rd_data_next = adc_zero_reg;
                `ADCRB_OFS_ADC_GAIN: rd_data_next = adc_gain_reg;
                default:
                    if (rd_res) begin
                        rd_data_next = result_reg[cmd_addr_i[2:0]];
                        rd_status_next = {cmd_addr_i[2:0], 1'b0,
                                          flags_reg[cmd_addr_i[2:0]],
                                          3'b000};
                        rd_status_vld_next =
                            cont_read_i || dump_status_i;        // [RULE20]
                    end else if (in_bank(cmd_addr_i,
                                         `ADCRB_OFS_CH_ZERO))
                        rd_data_next = ch_zero_reg[cmd_addr_i[2:0]];
                    else
                        rd_data_next = 24'h000000;               // [RULE25]
            endcase
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flags_reg    <= `ADCRB_RST_FLAGS;
            for (int i = 0; i < 8; i++) begin
                result_reg[i]  <= `ADCRB_RST_RESULT;             // [RULE18]
                ch_zero_reg[i] <= `ADCRB_RST_COEFF;
            end
            adc_zero_reg <= `ADCRB_RST_COEFF;                    // [RULE16]
            adc_gain_reg <= `ADCRB_RST_COEFF;
            test_reg     <= TEST_DEFAULT;
            csum_reg     <= CSUM_DEFAULT;
            pin_a_reg    <= 1'b0;
            pin_b_reg    <= 1'b0;
            dir_a_reg    <= `ADCRB_RST_DIR;                      // [RULE2]
            dir_b_reg    <= `ADCRB_RST_DIR;                      // [RULE2]
            rdy_fn_reg   <= 1'b0;
            low_pwr_reg  <= 1'b0;
            sync_en_reg  <= 1'b0;                                // [RULE6]
            upd_vld_reg  <= 1'b0;
            upd_ch_reg   <= 3'h0;
            upd_data_reg <= 24'h000000;
            rd_data_o    <= 24'h000000;
            rd_status_o  <= 8'h00;
            rd_status_vld_o <= 1'b0;
        end else begin
            flags_reg    <= flags_next;
            result_reg   <= result_next;
            ch_zero_reg  <= ch_zero_next;
            adc_zero_reg <= adc_zero_next;
            adc_gain_reg <= adc_gain_next;
            test_reg     <= test_next;
            csum_reg     <= csum_next;
            pin_a_reg    <= pin_a_next;
            pin_b_reg    <= pin_b_next;
            dir_a_reg    <= dir_a_next;
            dir_b_reg    <= dir_b_next;
            rdy_fn_reg   <= rdy_fn_next;
            low_pwr_reg  <= low_pwr_next;
            sync_en_reg  <= sync_en_next;
            upd_vld_reg  <= upd_vld_next;
            upd_ch_reg   <= upd_ch_next;
            upd_data_reg <= upd_data_next;
            rd_data_o    <= rd_data_next;
            rd_status_o  <= rd_status_next;
            rd_status_vld_o <= rd_status_vld_next;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_conv;
        conv_done_i ##1 (upd_vld_reg && !read_busy_i && !cal_done_i);
    endsequence
    property p_conv_sets;
        s_conv |=> flags_reg[$past(conv_ch_i, 2)] &&
            result_reg[$past(conv_ch_i, 2)] == $past(upd_data_reg);
    endproperty
    a_conv_sets: assert property (p_conv_sets) // [RULE9]
        else $error("conversion did not set flag and data");
    property p_read_clears;
        rd_res && !(upd_vld_reg && upd_ch_reg == cmd_addr_i[2:0])
            && !cal_done_i |=> !flags_reg[$past(cmd_addr_i[2:0])];
    endproperty
    a_read_clears: assert property (p_read_clears) // [RULE10]
        else $error("data read left ready flag set");
    property p_mode_clears;
        mode_write_i && !upd_vld_reg && !cal_done_i |=> flags_reg == 8'h00;
    endproperty
    a_mode_clears: assert property (p_mode_clears) // [RULE12]
        else $error("mode write left ready flags set");
    property p_cal_flags;
        (mode_cal_i && !cal_done_i && !upd_vld_reg) ##1 cal_done_i
            |-> flags_reg == 8'h00 ##1 flags_reg == 8'hff;
    endproperty
    a_cal_flags: assert property (p_cal_flags) // [RULE13]
        else $error("calibration flag sequence wrong");
    property p_skip;
        upd_vld_reg && read_busy_i |=>
            result_reg[$past(upd_ch_reg)] == $past(result_reg[upd_ch_reg]);
    endproperty
    a_skip: assert property (p_skip) // [RULE19]
        else $error("result overwritten during read");
    property p_idle_guard;
        wr && cmd_addr_i == 6'h06 && !mode_idle_i && !cal_done_i
            |=> $stable(adc_zero_reg);
    endproperty
    a_idle_guard: assert property (p_idle_guard) // [RULE15]
        else $error("coefficient written outside idle");
    property p_ready_any;
        !rdy_fn_reg |-> ready_n_o == (flags_reg == 8'h00);
    endproperty
    a_ready_any: assert property (p_ready_any) // [RULE3]
        else $error("ready output mismatch");
    property p_revision;
        rd && cmd_addr_i == 6'h02 |=> rd_data_o == {16'h0000, REVISION_CODE,
                                                    `ADCRB_GENERIC_CODE};
    endproperty
    a_revision: assert property (p_revision) // [RULE7]
        else $error("revision readback wrong");
    property p_pin_out;
        !dir_a_reg |-> !port_pin_a_oe_n_o && port_pin_a_o == pin_a_reg;
    endproperty
    a_pin_out: assert property (p_pin_out) // [RULE1]
        else $error("output pin not driven from port bit");
endmodule
`default_nettype wire

// ---- testbench/adcrb_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module adcrb_host_model (
    input  wire logic        core_clk_i,
    output logic             cmd_valid_o,
    output logic             cmd_rw_o,
    output logic [5:0]       cmd_addr_o,
    output logic [23:0]      cmd_wdata_o
);
    logic [23:0] exp_q[$];
    logic        vld_q[$];
    initial begin
        cmd_valid_o = 1'b0;
        cmd_rw_o    = 1'b0;
        cmd_addr_o  = 6'h00;
        cmd_wdata_o = 24'h000000;
    end
    // ----------------------------------------
    // Register accesses
    // ----------------------------------------
    // Strobe drops for a cycle between calls, so no double drive
    task automatic access(input logic rw, input logic [5:0] addr,
                          input logic [23:0] data);
        @(posedge core_clk_i);
        cmd_valid_o <= 1'b1;
        cmd_rw_o    <= rw;
        cmd_addr_o  <= addr;
        cmd_wdata_o <= data;
        @(posedge core_clk_i);
        cmd_valid_o <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] addr, input logic [23:0] data);
        if (addr == 6'h03) begin
            return;
        end
        if (addr == 6'h01) begin
            data[1] = 1'b0;
        end
        access(1'b0, addr, data);
    endtask
    // Expectation noted first, the watcher pops it when data shows
    task automatic rd(input logic [5:0] addr, input logic [23:0] exp_data,
                      input logic exp_vld);
        exp_q.push_back(exp_data);
        vld_q.push_back(exp_vld);
        access(1'b1, addr, 24'h000000);
    endtask
endmodule
`default_nettype wire

// ---- testbench/adcrb_regs_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "adcrb_regs.svh"
module adcrb_regs_test;
    logic core_clk_i = 1'b0, rst_n_i, read_busy_i, cont_read_i;
    logic dump_status_i, mode_write_i, mode_wide_i, mode_idle_i;
    logic mode_cal_i, conv_done_i, cal_done_i, ext_a, ext_b, rd_seen;
    logic [7:0]  ch_enable_i;
    logic [2:0]  conv_ch_i, cal_ch_i;
    logic [1:0]  cal_kind_i;
    logic [23:0] conv_raw_i, cal_coeff_i, raw, exp_c;
    logic        cmd_valid, cmd_rw, pin_a_o, pin_b_o, a_oe_n, b_oe_n;
    logic [5:0]  cmd_addr;
    logic [23:0] cmd_wdata, rd_data_o;
    logic        filter_sync_o, ready_n_o, low_power_select_o, rd_status_vld_o;
    logic [7:0]  rd_status_o;
    wire         pin_a = a_oe_n ? ext_a : pin_a_o;
    wire         pin_b = b_oe_n ? ext_b : pin_b_o;
    int          seed, k, cycles = 0, fail_count = 0, check_count = 0;
    localparam logic [3:0] REV = 4'h5; // Arbitrary value
    always #5 core_clk_i = ~core_clk_i;
    adcrb_host_model host (.core_clk_i(core_clk_i), .cmd_valid_o(cmd_valid),
        .cmd_rw_o(cmd_rw), .cmd_addr_o(cmd_addr), .cmd_wdata_o(cmd_wdata));
    adcrb_regs #(.REVISION_CODE(REV)) dut (.core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid), .cmd_rw_i(cmd_rw),
        .cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata),
        .rd_data_o(rd_data_o), .rd_status_o(rd_status_o),
        .rd_status_vld_o(rd_status_vld_o), .read_busy_i(read_busy_i),
        .cont_read_i(cont_read_i), .dump_status_i(dump_status_i),
        .mode_write_i(mode_write_i), .mode_wide_i(mode_wide_i),
        .mode_idle_i(mode_idle_i), .mode_cal_i(mode_cal_i),
        .ch_enable_i(ch_enable_i), .conv_done_i(conv_done_i),
        .conv_ch_i(conv_ch_i), .conv_raw_i(conv_raw_i),
        .cal_done_i(cal_done_i), .cal_kind_i(cal_kind_i),
        .cal_ch_i(cal_ch_i), .cal_coeff_i(cal_coeff_i),
        .port_pin_a_i(pin_a), .port_pin_a_o(pin_a_o),
        .port_pin_a_oe_n_o(a_oe_n), .port_pin_b_i(pin_b),
        .port_pin_b_o(pin_b_o), .port_pin_b_oe_n_o(b_oe_n),
        .filter_sync_o(filter_sync_o), .ready_n_o(ready_n_o),
        .low_power_select_o(low_power_select_o));
    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic chk_word(input string nm, input logic [23:0] e,
                            input logic [23:0] s);
        check_count++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic chk_bit(input string nm, input logic e, input logic s);
        check_count++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %s expected %b seen %b", nm, e, s);
        end
    endtask
    task automatic wrap_up();
        if (fail_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Read data lands at the taking edge, so compare mid-cycle after it
    always @(posedge core_clk_i) rd_seen <= cmd_valid && cmd_rw;
    always @(negedge core_clk_i) begin
        if (rd_seen === 1'b1) begin
            chk_word("rd_data", host.exp_q.pop_front(), rd_data_o);
            chk_bit("rd_status_vld", host.vld_q.pop_front(), rd_status_vld_o);
        end
    end
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            wrap_up();
        end
    end
    // Busy is raised on the cycle the result would land
    task automatic conv(input logic [2:0] ch, input logic [23:0] r,
                        input logic busy);
        @(posedge core_clk_i);
        conv_done_i <= 1'b1;
        conv_ch_i   <= ch;
        conv_raw_i  <= r;
        @(posedge core_clk_i);
        conv_done_i <= 1'b0;
        read_busy_i <= busy;
        @(posedge core_clk_i);
        read_busy_i <= 1'b0;
        @(posedge core_clk_i);
        #1;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        seed = 74473;
        {rst_n_i, read_busy_i, cont_read_i, dump_status_i} = 4'h0;
        {mode_write_i, mode_wide_i, mode_idle_i, mode_cal_i} = 4'h0;
        {conv_done_i, cal_done_i, ext_b, ext_a} = 4'h1;
        {ch_enable_i, conv_ch_i, cal_ch_i, cal_kind_i} = 16'h0000;
        {conv_raw_i, cal_coeff_i} = 48'h0;
        repeat (16) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        host.rd(6'h01, 24'h0000b0, 1'b0);
        host.rd(6'h02, {16'h0000, REV, `ADCRB_GENERIC_CODE}, 1'b0);
        host.rd(6'h04, 24'h000000, 1'b0);
        host.rd(6'h08, 24'h008000, 1'b0);
        host.rd(6'h06, 24'h800000, 1'b0);
        host.rd(6'h17, 24'h800000, 1'b0);
        host.rd(6'h3f, 24'h000000, 1'b0);
        host.wr(6'h01, 24'h000044);
        @(posedge core_clk_i);
        #1;
        chk_bit("pin_a_oe_n", 1'b0, a_oe_n);
        chk_bit("pin_a", 1'b0, pin_a_o);
        chk_bit("pin_b", 1'b1, pin_b_o);
        chk_bit("low_power", 1'b1, low_power_select_o);
        host.rd(6'h01, 24'h000044, 1'b0);
        host.wr(6'h01, 24'h000031);
        host.rd(6'h01, 24'h0000b1, 1'b0);
        chk_bit("filter_sync", 1'b1, filter_sync_o);
        for (k = 0; k < 4; k++) begin
            raw = 24'($random(seed));
            ext_a <= raw[0];
            host.rd(6'h01, {16'h0000, raw[0], 7'h31}, 1'b0);
        end
        raw = 24'($random(seed));
        conv(3'd3, raw, 1'b0);
        chk_bit("ready_n", 1'b0, ready_n_o);
        host.rd(6'h04, 24'h000008, 1'b0);
        cont_read_i <= 1'b1;
        host.rd(6'h0b, {8'h00, raw[23:8]}, 1'b1);
        #1;
        chk_word("rd_status", 24'h68, {16'h0000, rd_status_o});
        cont_read_i <= 1'b0;
        host.rd(6'h04, 24'h000000, 1'b0);
        conv(3'd3, raw ^ 24'h5a5a5a, 1'b0);
        conv(3'd3, ~raw, 1'b1);
        chk_bit("ready_n", 1'b1, ready_n_o);
        dump_status_i <= 1'b1;
        host.rd(6'h0b, {8'h00, raw[23:8] ^ 16'h5a5a},
                1'b1);
        #1;
        chk_word("rd_status", 24'h60, {16'h0000, rd_status_o});
        dump_status_i <= 1'b0;
        mode_wide_i <= 1'b1;
        raw = 24'($random(seed));
        conv(3'd5, raw, 1'b0);
        host.rd(6'h0d, raw, 1'b0);
        conv(3'd5, raw, 1'b0);
        host.wr(6'h01, 24'h000038);
        ch_enable_i <= 8'h09;
        conv(3'd0, raw, 1'b0);
        chk_bit("ready_n", 1'b1, ready_n_o);
        conv(3'd3, raw, 1'b0);
        chk_bit("ready_n", 1'b0, ready_n_o);
        host.rd(6'h04, 24'h000029, 1'b0);
        @(posedge core_clk_i);
        mode_write_i <= 1'b1;
        @(posedge core_clk_i);
        mode_write_i <= 1'b0;
        host.rd(6'h04, 24'h000000, 1'b0);
        host.wr(6'h06, 24'h654321);
        host.rd(6'h06, 24'h800000, 1'b0);
        host.wr(6'h07, 24'h123456);
        host.rd(6'h07, 24'h800000, 1'b0);
        mode_idle_i <= 1'b1;
        host.wr(6'h07, 24'h123456);
        host.rd(6'h07, 24'h123456, 1'b0);
        host.wr(6'h17, 24'hffffff);
        host.rd(6'h17, `ADCRB_CH_ZERO_MASK, 1'b0);
        host.wr(6'h05, 24'h00a5c3);
        host.rd(6'h05, 24'h00a5c3, 1'b0);
        mode_idle_i <= 1'b0;
        conv(3'd1, raw, 1'b0);
        for (k = 0; k < 3; k++) begin
            mode_cal_i <= 1'b1;
            host.rd(6'h04, 24'h000000, 1'b0);
            raw = 24'($random(seed));
            exp_c = (k == 2) ? (raw & `ADCRB_CH_ZERO_MASK) : raw;
            @(posedge core_clk_i);
            cal_done_i  <= 1'b1;
            cal_kind_i  <= k[1:0];
            cal_ch_i    <= 3'd2;
            cal_coeff_i <= raw;
            @(posedge core_clk_i);
            cal_done_i <= 1'b0;
            mode_cal_i <= 1'b0;
            host.rd(6'h04, 24'h0000ff, 1'b0);
            host.rd((k == 0) ? 6'h06 : (k == 1) ? 6'h07 : 6'h12, exp_c,
                    1'b0);
        end
        repeat (3) @(posedge core_clk_i);
        wrap_up();
    end
endmodule
`default_nettype wire
